// *** rtl/erma_core_ctl.sv ***
// Purpose: Exception return, state restore and data memory access logic.
// Assumes: All inputs come from core logic on mclk_in; one access at a time.
// Notes:   Exception entry wins over a return presented in the same cycle.
`include "erma_defines.svh"

// Summary of operation
// - Return with current set zero restores state from the exception copy.
// - Return with nonzero current set restores state from the shadow copy.
// - Return jumps to return address of the set active before restore.
// - Return may clear the nonmaskable mode bit but never sets it.
// - Return switches back to the previously active register set.
// - Taking an exception stores the next instruction address as return address.
// - Addresses are 32-bit byte addresses in one shared 4 GB space.
// - Unmapped addresses give undefined results and are not detected.
// - Data bus is 32 bits with byte, half-word and word accesses.
// - Multi-byte data is little-endian, high bytes at high addresses.
// - With an MMU the full 32-bit physical address is passed on.
// - Without MMU, address bit 31 may select uncached access, 2 GB space.
// - With an MMU it decides cacheability and bit 31 is ordinary.
// - Uncached word accesses bypass cache and write buffer to the bus.
// - Without a cache, cache management operations do nothing.
// - Cache index uses virtual address, tag uses physical address.
// - Cache tag carries the whole physical frame number.
// - Registers and memory exchange data only by loads and stores.
// - Uncached accesses reach the bus in order and are never dropped.
module erma_core_ctl
  import erma_pkg::*;
(
  // Clock and reset.
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  // Exception entry.
  input  wire logic         exc_take_in,
  input  wire logic         exc_nmi_in,
  input  wire logic [5:0]   exc_set_in,
  input  wire logic [31:0]  exc_next_pc_in,
  // Exception return and software return address write.
  input  wire logic         eret_in,
  input  wire logic         ea_wr_in,
  input  wire logic [31:0]  ea_wdata_in,
  // Load and store requests.
  input  wire logic         mreq_valid_in,
  input  wire erma_mreq_t   mreq_in,
  input  wire logic [31:0]  mmu_paddr_in,
  input  wire logic         mmu_uncached_in,
  input  wire logic         cache_op_in,
  // Data bus answer.
  input  wire logic         bus_ack_in,
  input  wire logic [31:0]  bus_rdata_in,
  // Processor state and program counter.
  output logic              pc_load_out,
  output logic [31:0]       pc_out,
  output erma_status_t      status_out,
  // Data bus request.
  output erma_bus_t         bus_out,
  output erma_cache_t       cache_out,
  output logic              cache_op_out,
  // Access completion.
  output logic              mreq_ready_out,
  output logic              ld_valid_out,
  output logic [31:0]       ld_data_out
);

  //////////////////////////////////////////////////////////////////////////////
  // State registers.
  erma_status_t status_q, status_d;
  erma_status_t estatus_q;
  erma_status_t sstatus_q;
  logic [31:0]  ea_q [`ERMA_NSETS];
  logic         pc_load_q;
  logic [31:0]  pc_q;

  // Current set index into the return address array.
  logic [`ERMA_SET_W-1:0] cur_set;
  logic [`ERMA_SET_W-1:0] new_set;
  assign cur_set = status_q.active_reg_set_field[`ERMA_SET_W-1:0];
  assign new_set = exc_set_in[`ERMA_SET_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Exception return decode.
  wire          eret_go = eret_in & ~exc_take_in;
  wire          use_shadow = (status_q.active_reg_set_field != 6'h00);
  erma_status_t restored;
  erma_status_t eret_status;
  // The saved copy is chosen by the set that is active before the return.
  assign restored = use_shadow ? sstatus_q : estatus_q;
  // The mode bit may only fall: a stale saved copy cannot enter that mode.
  always_comb begin
    eret_status     = restored;
    eret_status.nmi = status_q.nmi & restored.nmi;
  end

  // Exception entry state: handler set, previous set kept for the return.
  erma_status_t exc_status;
  always_comb begin
    exc_status     = status_q;
    exc_status.pie = 1'h0;
    exc_status.prs = status_q.active_reg_set_field;
    exc_status.active_reg_set_field = exc_set_in;
    exc_status.nmi = status_q.nmi | exc_nmi_in;
  end

  // Next state word.
  assign status_d = exc_take_in ? exc_status :
                    eret_go     ? eret_status : status_q;

  //////////////////////////////////////////////////////////////////////////////
  // State and program counter update; all three move in one edge.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      status_q  <= `ERMA_STATUS_RST;
      pc_load_q <= 1'h0;
      pc_q      <= `ERMA_PC_RST;
    end else begin
      status_q  <= status_d;
      pc_load_q <= eret_go;
      if (eret_go) begin
        pc_q <= ea_q[cur_set];
      end
    end
  end

  // Saved copies; the shadow copy serves handlers running in a shadow set.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      estatus_q <= `ERMA_STATUS_RST;
      sstatus_q <= `ERMA_STATUS_RST;
    end else if (exc_take_in) begin
      if (exc_set_in == 6'h00) begin
        estatus_q <= status_q;
      end else begin
        sstatus_q <= status_q;
      end
    end
  end

  // Return address per set; exception entry outranks a software write.
  genvar gi;
  generate
    for (gi = 0; gi < `ERMA_NSETS; gi++) begin : g_ea
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          ea_q[gi] <= `ERMA_PC_RST;
        end else if (exc_take_in && new_set == `ERMA_SET_W'(gi)) begin
          ea_q[gi] <= exc_next_pc_in;
        end else if (ea_wr_in && !exc_take_in && cur_set == `ERMA_SET_W'(gi)) begin
          ea_q[gi] <= ea_wdata_in;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Byte lane functions for the 32-bit data bus.
  function automatic logic [3:0] lane_be(input erma_size_t sz, input logic [1:0] off);
    unique case (sz)
      ERMA_BYTE: lane_be = 4'h1 << off;
      ERMA_HALF: lane_be = 4'h3 << {off[1], 1'h0};
      default:   lane_be = 4'hF;
    endcase
  endfunction

  function automatic logic [31:0] lane_wr(input erma_size_t sz, input logic [31:0] d);
    unique case (sz)
      ERMA_BYTE: lane_wr = {4{d[7:0]}};
      ERMA_HALF: lane_wr = {2{d[15:0]}};
      default:   lane_wr = d;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Access attributes. Bit 31 bypass halves the space; an MMU overrides it.
  wire        idle = mreq_ready_out;
  wire        take = mreq_valid_in & idle;
  wire [31:0] va = mreq_in.addr;
  wire        b31_unc = `ERMA_HAS_B31 & va[`ERMA_BYPASS_BIT];
  wire        unc = mreq_in.io | (`ERMA_HAS_MMU ? mmu_uncached_in : b31_unc);
  wire [31:0] pa_b31 = {1'h0, va[30:0]};
  wire [31:0] pa = `ERMA_HAS_MMU ? mmu_paddr_in :
                   (`ERMA_HAS_B31 ? pa_b31 : va);
  wire [3:0]  be = lane_be(mreq_in.size, va[1:0]);
  wire [31:0] wd = lane_wr(mreq_in.size, mreq_in.wdata);
  // Index bits above the page offset stay virtual, the tag is physical.
  erma_cache_t cache_d;
  assign cache_d.index = va[`ERMA_IDX_MSB:`ERMA_IDX_LSB];
  assign cache_d.tag   = pa[31:`ERMA_PAGE_W];
  // With no cache fitted, maintenance operations are dropped here.
  wire cop = cache_op_in & `ERMA_HAS_CACHE;

  //////////////////////////////////////////////////////////////////////////////
  // Bus issue. One access outstanding, no buffer, so order is kept and no
  // access is merged or skipped; the cost is a stall per access.
  // Unmapped addresses are issued like any other and never flagged.
  erma_size_t pend_size_q;
  logic [1:0] pend_off_q;
  logic       pend_sext_q;
  logic       pend_rd_q;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_out        <= '0;
      cache_out      <= '0;
      mreq_ready_out <= 1'h1;
    end else if (take) begin
      bus_out.addr     <= pa;
      bus_out.wdata    <= wd;
      bus_out.be       <= be;
      bus_out.rd       <= ~mreq_in.wr;
      bus_out.wr       <= mreq_in.wr;
      bus_out.uncached <= unc;
      cache_out        <= cache_d;
      mreq_ready_out   <= 1'h0;
    end else if (bus_ack_in && !idle) begin
      bus_out.rd     <= 1'h0;
      bus_out.wr     <= 1'h0;
      mreq_ready_out <= 1'h1;
    end
  end

  // Context of the outstanding load for lane extraction.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_size_q <= ERMA_WORD;
      pend_off_q  <= 2'h0;
      pend_sext_q <= 1'h0;
      pend_rd_q   <= 1'h0;
    end else if (take) begin
      pend_size_q <= mreq_in.size;
      pend_off_q  <= va[1:0];
      pend_sext_q <= mreq_in.sext;
      pend_rd_q   <= ~mreq_in.wr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Load data: shift the addressed lane down, then sign or zero extend.
  wire [31:0] rsh = bus_rdata_in >> {pend_off_q, 3'h0};
  logic [31:0] ld_d;
  always_comb begin
    unique case (pend_size_q)
      ERMA_BYTE: ld_d = {{24{pend_sext_q & rsh[7]}}, rsh[7:0]};
      ERMA_HALF: ld_d = {{16{pend_sext_q & rsh[15]}}, rsh[15:0]};
      default:   ld_d = rsh;
    endcase
  end

  // Load completion and cache operation strobe.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ld_valid_out <= 1'h0;
      ld_data_out  <= 32'h00000000;
      cache_op_out <= 1'h0;
    end else begin
      ld_valid_out <= bus_ack_in & ~idle & pend_rd_q;
      cache_op_out <= cop;
      if (bus_ack_in && !idle && pend_rd_q) begin
        ld_data_out <= ld_d;
      end
    end
  end

  // Registered outputs.
  assign pc_load_out = pc_load_q;
  assign pc_out      = pc_q;
  assign status_out  = status_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_eret_from_est: assert property (eret_go && status_q.active_reg_set_field == 6'h00 |=>
    status_q.active_reg_set_field == $past(estatus_q.active_reg_set_field) && status_q.il == $past(estatus_q.il))
    else $error("return from set zero did not use exception copy");

  a_eret_from_sst: assert property (eret_go && status_q.active_reg_set_field != 6'h00 |=>
    status_q.active_reg_set_field == $past(sstatus_q.active_reg_set_field) && status_q.pie == $past(sstatus_q.pie))
    else $error("return from shadow set did not use shadow copy");

  a_eret_pc_ea: assert property (eret_go |=> pc_load_out &&
    pc_out == $past(ea_q[cur_set]))
    else $error("return target differs from saved return address");

  a_nmi_no_set: assert property (eret_go && !status_q.nmi |=> !status_q.nmi)
    else $error("return entered nonmaskable mode");

  a_set_switch: assert property (exc_take_in && exc_set_in != 6'h00 ##1 !exc_take_in
    ##1 eret_go |=> status_q.active_reg_set_field == $past(status_q.prs))
    else $error("return did not switch back to previous set");

  a_exc_ea_load: assert property (exc_take_in |=>
    ea_q[$past(new_set)] == $past(exc_next_pc_in) && status_q.active_reg_set_field == $past(exc_set_in))
    else $error("exception entry did not save return address");

  a_b31_bypass: assert property (take && va[31] |=> bus_out.uncached &&
    !bus_out.addr[31])
    else $error("bit 31 access not uncached or not cleared");

  a_io_uncached: assert property (take && mreq_in.io |=> bus_out.uncached)
    else $error("io access marked cacheable");

  a_one_outst: assert property (take |=> !mreq_ready_out &&
    (bus_out.rd || bus_out.wr) until_with bus_ack_in)
    else $error("access dropped or overlapped before answer");

  a_le_byte_be: assert property (take && mreq_in.size == ERMA_BYTE |=>
    bus_out.be == (4'h1 << $past(va[1:0])))
    else $error("byte enable not little-endian");

  a_cache_noop: assert property (cache_op_in |=> !cache_op_out)
    else $error("cache operation not dropped without cache");

  c_eret_shadow: cover property (exc_take_in && exc_set_in != 6'h00 ##[1:8] eret_go);
  c_uncached_ld: cover property (take && unc && !mreq_in.wr ##[1:8] ld_valid_out);
  c_byte_store:  cover property (take && mreq_in.wr && mreq_in.size == ERMA_BYTE);
  c_nmi_exit:    cover property (eret_go && status_q.nmi && !restored.nmi);

endmodule

// *** rtl/erma_defines.svh ***
// Purpose: Constants of the exception return and memory access unit.
// Assumes: Included by its bare name wherever the constants are needed.
// Notes:   Configuration options are fixed here, not in module ports.
`ifndef ERMA_DEFINES_SVH
`define ERMA_DEFINES_SVH
// Register sets and the set index width.
`define ERMA_NSETS      4
`define ERMA_SET_W      2
// Address and data widths.
`define ERMA_ADDR_W     32
`define ERMA_DATA_W     32
// Address bit that selects uncached access without an MMU.
`define ERMA_BYPASS_BIT 31
// Page offset width (4 KB page) and cache line index field.
`define ERMA_PAGE_W     12
`define ERMA_IDX_LSB    4
`define ERMA_IDX_MSB    15
// Build options: MMU present, bit-31 bypass fitted, cache fitted.
`define ERMA_HAS_MMU    1'h0
`define ERMA_HAS_B31    1'h1
`define ERMA_HAS_CACHE  1'h0
// Reset values.
`define ERMA_STATUS_RST 32'h00000000
`define ERMA_PC_RST     32'h00000000
`endif

// *** rtl/erma_pkg.sv ***
// Purpose: Types shared by the exception return and memory access unit.
// Assumes: Widths match erma_defines.svh.
// Notes:   Status layout packs into one 32-bit word.
package erma_pkg;
  // Access size of a load or store.
  typedef enum logic [1:0] {
    ERMA_BYTE,
    ERMA_HALF,
    ERMA_WORD
  } erma_size_t;
  // Processor state word.
  typedef struct packed {
    logic [7:0] rsv;
    logic       rsie;
    logic       nmi;
    logic [5:0] prs;
    logic [5:0] active_reg_set_field;
    logic [5:0] il;
    logic       ih;
    logic       eh;
    logic       u;
    logic       pie;
  } erma_status_t;
  // Load or store request from the pipeline.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    erma_size_t  size;
    logic        wr;
    logic        io;
    logic        sext;
  } erma_mreq_t;
  // Data bus request towards memory and peripherals.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        rd;
    logic        wr;
    logic        uncached;
  } erma_bus_t;
  // Cache lookup attributes of an access.
  typedef struct packed {
    logic [11:0] index;
    logic [19:0] tag;
  } erma_cache_t;
endpackage

// *** verification/erma_mem_model.sv ***
// Purpose: Memory model on the data bus of the unit.
// Assumes: One access at a time; words indexed by address bits 5 to 2.
// Notes:   Answer delay steps from 0 to 3 cycles, so slow replies occur.
module erma_mem_model
  import erma_pkg::*;
(
  // Clock and bus request.
  input  wire logic      mclk_in,
  input  wire erma_bus_t req_in,
  // Answer.
  output logic           ack_out,
  output logic [31:0]    rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [16];
  logic [1:0]  wait_q;
  logic [1:0]  dly_q;
  // Start empty and idle.
  initial begin
    ack_out = 1'b0;
    rdata_out = 32'h0;
    wait_q = 2'h0;
    dly_q = 2'h0;
    foreach (mem[i]) mem[i] = 32'h0;
  end
  // Idle read data turns over every cycle, so a stale sample never matches.
  always @(posedge mclk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if ((req_in.rd || req_in.wr) && !ack_out) begin
      if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else begin
        ack_out <= 1'b1;
        rdata_out <= mem[req_in.addr[5:2]];
        wait_q <= dly_q;
        dly_q <= dly_q + 2'h1;
        for (int k = 0; k < 4; k++) begin
          if (req_in.wr && req_in.be[k]) begin
            mem[req_in.addr[5:2]][8*k +: 8] <= req_in.wdata[8*k +: 8];
          end
        end
      end
    end
  end
endmodule

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench of erma_core_ctl.
// Assumes: Build options no MMU, bit-31 bypass on, no cache.
// Notes:   Drivers queue expected results; a monitor compares them.
module tb_top
  import erma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         mclk_in, rst_in, exc_take_in, exc_nmi_in, eret_in, ea_wr_in;
  logic         mreq_valid_in, mmu_uncached_in, cache_op_in, bus_ack_in;
  logic         pc_load_out, cache_op_out, mreq_ready_out, ld_valid_out;
  logic [5:0]   exc_set_in;
  logic [31:0]  exc_next_pc_in, ea_wdata_in, mmu_paddr_in, bus_rdata_in;
  logic [31:0]  pc_out, ld_data_out, r, a;
  erma_mreq_t   mreq_in;
  erma_status_t status_out, cur, est, sst;
  erma_bus_t    bus_out;
  erma_cache_t  cache_out;
  erma_size_t   sz;
  logic [31:0]  ea [4];
  logic [31:0]  sh [16];
  logic [31:0]  ld_q [$];
  logic [45:0]  pc_q [$];
  logic [45:0]  e;
  int           failures, n_checks, seed;

  erma_core_ctl dut (.mclk_in, .rst_in, .exc_take_in, .exc_nmi_in, .exc_set_in,
    .exc_next_pc_in, .eret_in, .ea_wr_in, .ea_wdata_in, .mreq_valid_in, .mreq_in,
    .mmu_paddr_in, .mmu_uncached_in, .cache_op_in, .bus_ack_in, .bus_rdata_in,
    .pc_load_out, .pc_out, .status_out, .bus_out, .cache_out, .cache_op_out,
    .mreq_ready_out, .ld_valid_out, .ld_data_out);
  erma_mem_model mem_i (.mclk_in, .req_in(bus_out), .ack_out(bus_ack_in),
    .rdata_out(bus_rdata_in));

  ////////////////////////////////////////
  // Only the fields that the return logic owns are compared.
  function automatic logic [13:0] st(input erma_status_t s);
    return {s.active_reg_set_field, s.prs, s.nmi, s.pie};
  endfunction
  task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Exception entry; er also raises return and address write, which must be ignored.
  task automatic exc(input logic [1:0] s, input logic nmi, input logic [31:0] pc,
                     input logic er);
    exc_take_in <= 1'b1;
    exc_set_in <= {4'h0, s};
    exc_nmi_in <= nmi;
    exc_next_pc_in <= pc;
    eret_in <= er;
    ea_wr_in <= er;
    ea_wdata_in <= 32'h0BAD0BAD;
    if (s == 2'h0) est = cur;
    else sst = cur;
    ea[s] = pc;
    cur.prs = cur.active_reg_set_field;
    cur.active_reg_set_field = {4'h0, s};
    cur.nmi = cur.nmi | nmi;
    cur.pie = 1'b0;
    @(posedge mclk_in);
    exc_take_in <= 1'b0;
    eret_in <= 1'b0;
    ea_wr_in <= 1'b0;
    @(negedge mclk_in);
    cmp("exc_state", st(status_out), st(cur));
    @(posedge mclk_in);
  endtask
  task automatic ret;
    erma_status_t nx;
    nx = (cur.active_reg_set_field == 6'h0) ? est : sst;
    nx.nmi = nx.nmi & cur.nmi;
    pc_q.push_back({ea[cur.active_reg_set_field[1:0]], st(nx)});
    cur = nx;
    eret_in <= 1'b1;
    @(posedge mclk_in);
    eret_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic ea_put(input logic [31:0] d);
    ea[cur.active_reg_set_field[1:0]] = d;
    ea_wr_in <= 1'b1;
    ea_wdata_in <= d;
    @(posedge mclk_in);
    ea_wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  // One load or store; the shadow memory predicts every load.
  task automatic mem(input logic [31:0] a, input erma_size_t sz, input logic wr,
                     input logic io, input logic sx, input logic [31:0] d);
    logic [3:0]  be;
    logic [31:0] rep, x;
    be = (sz == ERMA_BYTE) ? 4'h1 << a[1:0] : (sz == ERMA_HALF) ? 4'h3 << {a[1], 1'b0} : 4'hF;
    rep = (sz == ERMA_BYTE) ? {4{d[7:0]}} : (sz == ERMA_HALF) ? {2{d[15:0]}} : d;
    mreq_in <= '{addr: a, wdata: d, size: sz, wr: wr, io: io, sext: sx};
    mreq_valid_in <= 1'b1;
    @(posedge mclk_in);
    mreq_valid_in <= 1'b0;
    @(negedge mclk_in);
    cmp("bus_be", bus_out.be, be);
    cmp("bus_uncached", bus_out.uncached, io | a[31]);
    cmp("bus_addr", bus_out.addr, {1'b0, a[30:0]});
    cmp("bus_rdwr", {bus_out.rd, bus_out.wr}, {!wr, wr});
    cmp("cache_idx", cache_out.index, a[15:4]);
    cmp("cache_tag", cache_out.tag, {1'b0, a[30:12]});
    cmp("cache_op", cache_op_out, 1'b0);
    if (wr) begin
      cmp("bus_wdata", bus_out.wdata, rep);
      for (int k = 0; k < 4; k++) if (be[k]) sh[a[5:2]][8*k +: 8] = rep[8*k +: 8];
    end else begin
      x = sh[a[5:2]] >> {a[1:0], 3'h0};
      if (sz == ERMA_BYTE) x = {{24{sx & x[7]}}, x[7:0]};
      else if (sz == ERMA_HALF) x = {{16{sx & x[15]}}, x[15:0]};
      ld_q.push_back(x);
    end
    for (int k = 0; k < 10 && mreq_ready_out !== 1'b1; k++) @(negedge mclk_in);
    cmp("ready", mreq_ready_out, 1'b1);
    @(posedge mclk_in);
  endtask

  ////////////////////////////////////////
  // Monitor: every result takes the oldest note of its kind.
  always @(negedge mclk_in) begin
    if (ld_valid_out === 1'b1) begin
      if (ld_q.size() == 0) cmp("ld_extra", 32'h1, 32'h0);
      else cmp("ld_data", ld_data_out, ld_q.pop_front());
    end
    if (pc_load_out === 1'b1) begin
      if (pc_q.size() == 0) begin
        cmp("pc_extra", 32'h1, 32'h0);
      end else begin
        e = pc_q.pop_front();
        cmp("ret_pc", pc_out, e[45:14]);
        cmp("ret_state", st(status_out), e[13:0]);
      end
    end
  end
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // A run needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge mclk_in);
    failures++;
    wrap_up();
  end
  initial begin
    {exc_take_in, exc_nmi_in, eret_in, ea_wr_in, mreq_valid_in} = 5'h0;
    {mmu_uncached_in, cache_op_in, exc_set_in} = 8'h0;
    {exc_next_pc_in, ea_wdata_in, mmu_paddr_in} = 96'h0;
    mreq_in = '0;
    cur = '0;
    est = '0;
    sst = '0;
    foreach (ea[i]) ea[i] = 32'h0;
    foreach (sh[i]) sh[i] = 32'h0;
    failures = 0;
    n_checks = 0;
    seed = 32'hc7751552;
    rst_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    cmp("rst_state", st(status_out), 14'h0);
    cmp("rst_ready", mreq_ready_out, 1'b1);
    @(posedge mclk_in);
    exc(2'h0, 1'b0, 32'h00000100, 1'b0);
    ret();
    exc(2'h2, 1'b1, 32'h00000204, 1'b0);
    ret();
    exc(2'h1, 1'b1, 32'h00000300, 1'b0);
    exc(2'h0, 1'b0, 32'h00000404, 1'b1);
    ret();
    ea_put(32'h00000300 - 32'h4);
    ret();
    // The exception copy still holds the mode bit set while the core is out of it.
    ret();
    for (int k = 0; k < 48; k++) begin
      r = $random(seed);
      a = r & 32'h8000FFFF;
      sz = erma_size_t'(k % 3);
      if (sz == ERMA_HALF) a[0] = 1'b0;
      if (sz == ERMA_WORD) a[1:0] = 2'h0;
      mmu_paddr_in <= ~r;
      mmu_uncached_in <= r[16];
      cache_op_in <= r[17];
      mem(a, sz, r[18], r[19], r[20], $random(seed));
    end
    repeat (4) @(posedge mclk_in);
    cmp("left_over", ld_q.size() + pc_q.size(), 32'h0);
    wrap_up();
  end
endmodule
